/* File: verilog/lcdrst_pkg.sv */
// ==========================================================
// register map, fields and reset values
package lcdrst_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY = 8'h08;
  localparam logic [7:0] ADDR_BLINK = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ISTAT = 8'h14;
  localparam logic [7:0] ADDR_IMASK = 8'h18;
  // display_control0 fields
  localparam int C0_EN = 7;
  localparam int C0_SRC = 6;
  localparam int C0_FRAME_CLK = 3;
  localparam int C0_DUTY = 0;
  // display_control1 fields
  localparam int C1_IEN = 7;
  localparam int C1_WAI = 1;
  localparam int C1_STP = 0;
  // supply_control_reg fields
  localparam int SP_CPEN = 7;
  localparam int SP_PUMP_SEL = 6;
  localparam int SP_PUMP_CLK = 4;
  localparam int SP_VSUP = 0;
  // blink_control_reg fields
  localparam int BL_BLINK = 7;
  localparam int BL_ALT = 6;
  localparam int BL_BLANK = 5;
  localparam int BL_STYLE = 3;
  localparam int BL_RATE = 0;
  // display_status_reg fields
  localparam int ST_FLAG = 7;
  localparam int ST_BIAS = 2;
  localparam int ST_DRV = 1;
  localparam int ST_SETTLE = 0;
  // interrupt status and mask bits
  localparam int IS_FRAME = 0;
  localparam int IS_SETTLED = 1;
  // reset values
  localparam logic [7:0] RST_CTRL0 = 8'h03;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h41;
  localparam logic [7:0] RST_BLINK = 8'h00;
  localparam logic [2:0] DUTY_QUARTER = 3'h3;
  localparam logic [1:0] BIAS_THIRD = 2'h3;
  localparam logic [1:0] VSUP_VLL2_CORE = 2'h0;
  localparam logic [1:0] VSUP_VLL3_CORE = 2'h1;
  // outputs held off after pump enable, in timebase ticks
  localparam logic [4:0] SETTLE_TICKS = 5'h10;
  // bus answer state
  typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ANSWER = 1'b1} lcdrst_bus_type;
endpackage

/* File: verilog/lcdrst_top.sv */
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module lcdrst_top
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // events from the waveform side
  input wire logic i_frame_tick,
  input wire logic i_timebase_tick,
  // controls toward the glass and the supply
  output logic o_driver_enable,
  output logic o_core_supply,
  output logic o_powersw1,
  output logic o_powersw2,
  output logic o_pump_on,
  output logic [2:0] o_duty,
  output logic [1:0] o_bias,
  output logic [2:0] o_frame_clock_select,
  output logic [2:0] o_blink_rate,
  output logic o_irq
);

  // ==========================================================
  // registers
  logic [7:0] ctrl0_q; // display_control0
  logic [7:0] ctrl1_q; // display_control1
  logic [7:0] supply_q; // supply_control_reg
  logic [7:0] blink_q; // blink_control_reg
  logic frame_flag_q; // sticky frame flag, write one clears
  logic frame_flag_d;
  logic [1:0] istat_q; // read-clear event bits
  logic [1:0] istat_d;
  logic [1:0] imask_q; // gates istat onto irq
  logic [4:0] settle_q; // timebase ticks left with drivers off
  logic [4:0] settle_d;
  logic [31:0] rdata_q; // read data held for the answer
  lcdrst_pkg::lcdrst_bus_type bus_q; // bus answer state
  lcdrst_pkg::lcdrst_bus_type bus_d;

  // ==========================================================
  // bus decode
  wire req = i_read | i_write; // a request is pending
  wire accept = req & (bus_q == lcdrst_pkg::BUS_ANSWER); // edge where it completes
  wire wr_lane0 = accept & i_write & i_byteenable[0]; // low byte written
  wire [7:0] wbyte = i_writedata[7:0]; // written byte
  wire wr_c0 = wr_lane0 & (i_address == lcdrst_pkg::ADDR_CTRL0);
  wire wr_c1 = wr_lane0 & (i_address == lcdrst_pkg::ADDR_CTRL1);
  wire wr_sp = wr_lane0 & (i_address == lcdrst_pkg::ADDR_SUPPLY);
  wire wr_bl = wr_lane0 & (i_address == lcdrst_pkg::ADDR_BLINK);
  wire wr_st = wr_lane0 & (i_address == lcdrst_pkg::ADDR_STATUS);
  wire wr_im = wr_lane0 & (i_address == lcdrst_pkg::ADDR_IMASK);
  wire rd_is = accept & i_read & (i_address == lcdrst_pkg::ADDR_ISTAT);
  // pump enable rising by a write
  wire cpen_rise = wr_sp & wbyte[lcdrst_pkg::SP_CPEN] & ~supply_q[lcdrst_pkg::SP_CPEN];
  wire settling = (settle_q != 5'h00); // drivers forced off
  wire settle_done = settling & i_timebase_tick & (settle_q == 5'h01) & ~cpen_rise;
  wire [1:0] vsup = supply_q[lcdrst_pkg::SP_VSUP +: 2]; // supply_select

  // status read view
  wire [7:0] status_view = {frame_flag_q, 3'h0, lcdrst_pkg::BIAS_THIRD, o_driver_enable, settling};

  // read mux, unmapped reads return zero
  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] c0,
    input logic [7:0] c1, input logic [7:0] sp, input logic [7:0] bl,
    input logic [7:0] st, input logic [1:0] is, input logic [1:0] im);
    case (a)
      lcdrst_pkg::ADDR_CTRL0: read_mux = c0;
      lcdrst_pkg::ADDR_CTRL1: read_mux = c1;
      lcdrst_pkg::ADDR_SUPPLY: read_mux = sp;
      lcdrst_pkg::ADDR_BLINK: read_mux = bl;
      lcdrst_pkg::ADDR_STATUS: read_mux = st;
      lcdrst_pkg::ADDR_ISTAT: read_mux = {6'h00, is};
      lcdrst_pkg::ADDR_IMASK: read_mux = {6'h00, im};
      default: read_mux = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // next-state logic
  always_comb
  begin
    // one wait cycle, then answer
    case (bus_q)
      lcdrst_pkg::BUS_IDLE: bus_d = req ? lcdrst_pkg::BUS_ANSWER : lcdrst_pkg::BUS_IDLE;
      lcdrst_pkg::BUS_ANSWER: bus_d = lcdrst_pkg::BUS_IDLE;
      default: bus_d = lcdrst_pkg::BUS_IDLE;
    endcase
    // set wins over a write-one clear
    frame_flag_d = i_frame_tick | (frame_flag_q & ~(wr_st & wbyte[lcdrst_pkg::ST_FLAG]));
    // set wins over the read clear
    istat_d = {settle_done, i_frame_tick} | (istat_q & ~{2{rd_is}});
    // settle counter, reload beats a tick
    if (cpen_rise)
      settle_d = lcdrst_pkg::SETTLE_TICKS;
    else if (settling & i_timebase_tick)
      settle_d = settle_q - 5'h01;
    else
      settle_d = settle_q;
  end

  // ==========================================================
  // bus state and read data
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      bus_q <= lcdrst_pkg::BUS_IDLE;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      bus_q <= bus_d;
      // sample read data during the wait cycle
      if (req & (bus_q == lcdrst_pkg::BUS_IDLE))
        rdata_q <= {24'h00_0000, read_mux(i_address, ctrl0_q, ctrl1_q, supply_q, blink_q,
          status_view, istat_q, imask_q)};
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl0_q <= lcdrst_pkg::RST_CTRL0;
      ctrl1_q <= lcdrst_pkg::RST_CTRL1;
      supply_q <= lcdrst_pkg::RST_SUPPLY;
      blink_q <= lcdrst_pkg::RST_BLINK;
      imask_q <= 2'h0;
    end
    else
    begin
      if (wr_c0)
        ctrl0_q <= wbyte;
      if (wr_c1)
        ctrl1_q <= wbyte & 8'h83;
      if (wr_sp)
        supply_q <= wbyte & 8'hf3;
      if (wr_bl)
        blink_q <= wbyte & 8'hef;
      if (wr_im)
        imask_q <= wbyte[1:0];
    end
  end

  // ==========================================================
  // flags and settle counter
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      frame_flag_q <= 1'b0;
      istat_q <= 2'h0;
      settle_q <= 5'h00;
    end
    else
    begin
      frame_flag_q <= frame_flag_d;
      istat_q <= istat_d;
      settle_q <= settle_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_waitrequest = req & (bus_q == lcdrst_pkg::BUS_IDLE);
  assign o_readdata = rdata_q;
  // drivers high-impedance unless enabled and settled
  assign o_driver_enable = ctrl0_q[lcdrst_pkg::C0_EN] & ~settling;
  // core rail powers the module for codes 00 and 01
  assign o_core_supply = (vsup == lcdrst_pkg::VSUP_VLL2_CORE) | (vsup == lcdrst_pkg::VSUP_VLL3_CORE);
  assign o_powersw1 = (vsup == lcdrst_pkg::VSUP_VLL2_CORE);
  assign o_powersw2 = (vsup == lcdrst_pkg::VSUP_VLL3_CORE);
  // charge pump path, software keeps it on when core-powered
  assign o_pump_on = supply_q[lcdrst_pkg::SP_PUMP_SEL];
  assign o_duty = ctrl0_q[lcdrst_pkg::C0_DUTY +: 3];
  assign o_bias = lcdrst_pkg::BIAS_THIRD;
  assign o_frame_clock_select = ctrl0_q[lcdrst_pkg::C0_FRAME_CLK +: 3];
  assign o_blink_rate = blink_q[lcdrst_pkg::BL_RATE +: 3];
  // enabled frame flag or any unmasked event bit
  assign o_irq = (frame_flag_q & ctrl1_q[lcdrst_pkg::C1_IEN]) | (|(istat_q & imask_q));

  // ==========================================================
  // checks
  property p_core_supply;
    @(posedge i_clock) disable iff (i_rst)
    (vsup[1] == 1'b0) |-> o_core_supply;
  endproperty
  a_core_supply: assert property (p_core_supply) else $error("core supply not selected");

  property p_reset_off;
    @(posedge i_clock) $fell(i_rst) |-> !o_driver_enable && !ctrl0_q[lcdrst_pkg::C0_EN];
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("drivers on after reset");

  property p_reset_duty;
    @(posedge i_clock) $fell(i_rst) |-> (o_duty == lcdrst_pkg::DUTY_QUARTER) && (o_bias == 2'h3);
  endproperty
  a_reset_duty: assert property (p_reset_duty) else $error("reset duty or bias wrong");

  property p_reset_fields;
    @(posedge i_clock) $fell(i_rst) |-> (supply_q == 8'h41) && (o_frame_clock_select == 3'h0)
      && (o_blink_rate == 3'h0);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("reset fields wrong");

  property p_flag_set;
    @(posedge i_clock) disable iff (i_rst)
    i_frame_tick |=> frame_flag_q [*2] or (frame_flag_q ##1 $past(wr_st));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("frame flag not held");

  property p_flag_clear;
    @(posedge i_clock) disable iff (i_rst)
    (wr_st && wbyte[7] && !i_frame_tick) |=> !frame_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear flag");

  property p_irq;
    @(posedge i_clock) disable iff (i_rst)
    (frame_flag_q && ctrl1_q[7]) |-> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_settle;
    @(posedge i_clock) disable iff (i_rst)
    (settling && !cpen_rise) |-> !o_driver_enable ##1
      (settle_q == $past(settle_q) - {4'h0, $past(i_timebase_tick)});
  endproperty
  a_settle: assert property (p_settle) else $error("drivers on during settle");

  property p_settle_len;
    @(posedge i_clock) disable iff (i_rst)
    cpen_rise |=> (settle_q == 5'h10);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle count wrong");

  property p_zero_keeps;
    @(posedge i_clock) disable iff (i_rst)
    (wr_st && !wbyte[7] && frame_flag_q) |=> frame_flag_q && $stable(ctrl1_q);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed flag");

endmodule

/* File: test/lcdrst_glass.sv */
`timescale 1ns/1ps
// ====================
// glass model: counts frames shown while driven
module lcdrst_glass
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // drive state and frame strobe
  input wire logic i_driver_enable,
  input wire logic i_frame_tick,
  // frames seen lit
  output logic [7:0] o_lit_frames
);
  // a frame only shows while the electrodes are driven
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_lit_frames <= 8'h00;
    end
    else if (i_driver_enable && i_frame_tick)
    begin
      o_lit_frames <= o_lit_frames + 8'h01;
    end
  end
endmodule

/* File: test/lcd_reset_irq_setup_tb_top.sv */
`timescale 1ns/1ps
// ====================
// bench for the lcd control block
module lcd_reset_irq_setup_tb_top;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic i_frame_tick = 1'b0;
  logic i_timebase_tick = 1'b0;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_driver_enable, o_core_supply, o_powersw1, o_powersw2, o_pump_on, o_irq;
  logic [2:0] o_duty, o_frame_clock_select, o_blink_rate;
  logic [1:0] o_bias;
  logic [7:0] lit, rd, v, b;
  integer seed = 32'h966a;
  int fails = 0;
  int cmp_count = 0;
  int k;
  // 100 mhz clock
  always #5 i_clock = ~i_clock;
  lcdrst_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_byteenable(4'h1), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_frame_tick(i_frame_tick), .i_timebase_tick(i_timebase_tick),
    .o_driver_enable(o_driver_enable), .o_core_supply(o_core_supply), .o_powersw1(o_powersw1),
    .o_powersw2(o_powersw2), .o_pump_on(o_pump_on), .o_duty(o_duty), .o_bias(o_bias),
    .o_frame_clock_select(o_frame_clock_select), .o_blink_rate(o_blink_rate), .o_irq(o_irq));
  lcdrst_glass glass (.i_clock(i_clock), .i_rst(i_rst), .i_driver_enable(o_driver_enable),
    .i_frame_tick(i_frame_tick), .o_lit_frames(lit));
  // ====================
  // compare and report
  task automatic chk_bit(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // core rail expected for the two internal supply codes
  function automatic logic exp_core(input logic [1:0] c);
    return (c == lcdrst_pkg::VSUP_VLL2_CORE) || (c == lcdrst_pkg::VSUP_VLL3_CORE);
  endfunction
  // ====================
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_read <= ~wr;
    i_write <= wr;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    if (o_waitrequest !== 1'b0)
    begin
      fails++;
      conclude();
    end
    rd = o_readdata[7:0];
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(negedge i_clock);
  endtask
  // one-cycle event pulses, timebase or frame
  task automatic pulse(input logic tb, input int cnt);
    repeat (cnt)
    begin
      @(posedge i_clock);
      if (tb) i_timebase_tick <= 1'b1;
      else i_frame_tick <= 1'b1;
      @(posedge i_clock);
      i_timebase_tick <= 1'b0;
      i_frame_tick <= 1'b0;
    end
    @(negedge i_clock);
  endtask
  // defaults after any reset
  task automatic check_reset();
    chk_bit("drv_en", 1'b0, o_driver_enable);
    chk_byte("duty", {5'h0, lcdrst_pkg::DUTY_QUARTER}, {5'h0, o_duty});
    chk_byte("bias", {6'h0, lcdrst_pkg::BIAS_THIRD}, {6'h0, o_bias});
    bus(1'b0, lcdrst_pkg::ADDR_CTRL0, 8'h00);
    chk_byte("ctrl0", lcdrst_pkg::RST_CTRL0, rd);
    bus(1'b0, lcdrst_pkg::ADDR_SUPPLY, 8'h00);
    chk_byte("supply", lcdrst_pkg::RST_SUPPLY, rd);
    bus(1'b0, lcdrst_pkg::ADDR_BLINK, 8'h00);
    chk_byte("blink", lcdrst_pkg::RST_BLINK, rd);
  endtask
  // ====================
  // main sequence
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    check_reset();
    // every supply code, pump select kept on
    for (k = 0; k < 4; k++)
    begin
      v = {2'b01, 2'($random(seed)), 2'b00, 2'(k)};
      bus(1'b1, lcdrst_pkg::ADDR_SUPPLY, v);
      chk_bit("core", exp_core(2'(k)), o_core_supply);
      chk_bit("sw1", k == 0, o_powersw1);
      chk_bit("sw2", k == 1, o_powersw2);
      chk_bit("pump", 1'b1, o_pump_on);
    end
    // random clock, duty and blink fields
    repeat (6)
    begin
      v = {1'b0, 7'($random(seed))};
      b = 8'($random(seed));
      bus(1'b1, lcdrst_pkg::ADDR_CTRL0, v);
      bus(1'b1, lcdrst_pkg::ADDR_BLINK, b);
      chk_byte("duty", {5'h0, v[2:0]}, {5'h0, o_duty});
      chk_byte("frame_clk", {5'h0, v[5:3]}, {5'h0, o_frame_clock_select});
      chk_byte("blink_rate", {5'h0, b[2:0]}, {5'h0, o_blink_rate});
    end
    // sticky flag, zero write, enable gating, one-write clear
    bus(1'b1, lcdrst_pkg::ADDR_CTRL1, 8'h00);
    pulse(1'b0, 1);
    bus(1'b1, lcdrst_pkg::ADDR_STATUS, 8'h00);
    bus(1'b0, lcdrst_pkg::ADDR_STATUS, 8'h00);
    chk_bit("flag", 1'b1, rd[7]);
    chk_byte("bias_st", 8'h03, {6'h0, rd[3:2]});
    chk_bit("irq", 1'b0, o_irq);
    bus(1'b1, lcdrst_pkg::ADDR_CTRL1, 8'h80);
    chk_bit("irq", 1'b1, o_irq);
    bus(1'b1, lcdrst_pkg::ADDR_STATUS, 8'h80);
    chk_bit("irq", 1'b0, o_irq);
    bus(1'b0, lcdrst_pkg::ADDR_STATUS, 8'h00);
    chk_bit("flag", 1'b0, rd[7]);
    // masked status path, cleared by reading
    bus(1'b1, lcdrst_pkg::ADDR_CTRL1, 8'h00);
    bus(1'b0, lcdrst_pkg::ADDR_ISTAT, 8'h00);
    bus(1'b1, lcdrst_pkg::ADDR_IMASK, 8'h01);
    chk_bit("irq_m", 1'b0, o_irq);
    pulse(1'b0, 1);
    chk_bit("irq_m", 1'b1, o_irq);
    bus(1'b0, lcdrst_pkg::ADDR_ISTAT, 8'h00);
    chk_bit("istat0", 1'b1, rd[0]);
    chk_bit("irq_m", 1'b0, o_irq);
    // outputs held off for 16 ticks after pump enable
    bus(1'b1, lcdrst_pkg::ADDR_CTRL0, 8'h83);
    chk_bit("drv_en", 1'b1, o_driver_enable);
    b = lit;
    bus(1'b1, lcdrst_pkg::ADDR_SUPPLY, 8'hc1);
    chk_bit("drv_en", 1'b0, o_driver_enable);
    pulse(1'b1, 15);
    pulse(1'b0, 1);
    chk_bit("drv_en", 1'b0, o_driver_enable);
    pulse(1'b1, 1);
    chk_bit("drv_en", 1'b1, o_driver_enable);
    pulse(1'b0, 1);
    chk_byte("lit", b + 8'h01, lit);
    bus(1'b0, lcdrst_pkg::ADDR_ISTAT, 8'h00);
    chk_bit("istat1", 1'b1, rd[1]);
    // unmapped place reads zero
    bus(1'b1, 8'h1c, 8'hff);
    bus(1'b0, 8'h1c, 8'h00);
    chk_byte("unmapped", 8'h00, rd);
    // second reset in mid-run
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(negedge i_clock);
    chk_bit("drv_en", 1'b0, o_driver_enable);
    @(posedge i_clock);
    i_rst <= 1'b0;
    check_reset();
    chk_bit("irq", 1'b0, o_irq);
    // configuration written again before it is relied on
    bus(1'b1, lcdrst_pkg::ADDR_CTRL0, 8'h83);
    chk_bit("drv_en", 1'b1, o_driver_enable);
    conclude();
  end
endmodule
